// [hdl/tlpw_pkg.sv]
// Purpose: shared constants for the two-level page walker
// Assumes: 32-bit virtual addresses, 34-bit physical addresses
// Notes: register offsets are byte addresses on the apb bus
`default_nettype none
package tlpw_pkg;
  // ==========================================================
  // address layout
  localparam int VA_W = 32;
  localparam int PA_W = 34;
  localparam int PPN_W = 22;
  localparam int VPN_W = 10;
  localparam int OFF_W = 12;
  localparam int LEVELS = 2;
  localparam logic [33:0] BASE_PAGE_BYTES = 34'h000001000;
  localparam logic [33:0] ENTRY_BYTES = 34'h000000004;
  // ==========================================================
  // entry bit positions
  localparam int PTE_V = 0;
  localparam int PTE_R = 1;
  localparam int PTE_W = 2;
  localparam int PTE_X = 3;
  localparam int PTE_U = 4;
  localparam int PTE_G = 5;
  localparam int PTE_A = 6;
  localparam int PTE_D = 7;
  localparam int PTE_PPN_LO = 10;
  // ==========================================================
  // access types and privilege
  localparam logic [1:0] ACC_LOAD = 2'h0;
  localparam logic [1:0] ACC_STORE = 2'h1;
  localparam logic [1:0] ACC_FETCH = 2'h2;
  localparam logic [1:0] PRIV_U = 2'h0;
  localparam logic [1:0] PRIV_S = 2'h1;
  // ==========================================================
  // fault codes
  localparam logic [1:0] FLT_NONE = 2'h0;
  localparam logic [1:0] FLT_PAGE = 2'h1;
  localparam logic [1:0] FLT_ACCESS = 2'h2;
  // ==========================================================
  // apb register map
  localparam logic [7:0] REG_ROOT = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_FENCE = 8'h0c;
  localparam int CTRL_SUA = 0;
  localparam int CTRL_MXR = 1;
  localparam int CTRL_HWAD = 2;
  localparam int CTRL_ACT = 3;
  localparam logic [31:0] CTRL_RESET = 32'h00000004;
  localparam int CACHE_DEPTH = 4;
endpackage : tlpw_pkg
`default_nettype wire

// [hdl/tlpw_cache.sv]
// Purpose: small private translation cache for leaf entries
// Assumes: fills only from completed walks, never written back
// Notes: read-only and incoherent; flush discards everything
`default_nettype none
module tlpw_cache
  import tlpw_pkg::*;
#(
  parameter int DEPTH = CACHE_DEPTH,
  parameter int ASID_W = 9
)
(
  input wire logic clk_sys_i, // core clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic flush_i, // discard all entries
  input wire logic [19:0] look_vpn_i, // vpn looked up
  input wire logic [ASID_W-1:0] look_asid_i, // current asid
  output logic hit_o, // an entry matches
  output logic [31:0] hit_pte_o, // matching leaf entry
  output logic hit_mega_o, // matching entry is a megapage
  input wire logic fill_i, // install an entry
  input wire logic [19:0] fill_vpn_i, // vpn of the new entry
  input wire logic [ASID_W-1:0] fill_asid_i, // asid of new entry
  input wire logic [31:0] fill_pte_i, // leaf entry
  input wire logic fill_mega_i // leaf came from upper level
);
  logic [DEPTH-1:0] vld;
  logic [19:0] tag [DEPTH];
  logic [ASID_W-1:0] asid [DEPTH];
  logic [31:0] pte [DEPTH];
  logic [DEPTH-1:0] mega;
  logic [$clog2(DEPTH)-1:0] wptr;

  // ==========================================================
  // lookup: asid must match unless the mapping is global
  always_comb
  begin
    hit_o = 1'b0;
    hit_pte_o = 32'h00000000;
    hit_mega_o = 1'b0;
    for (int k = 0; k < DEPTH; k++)
    begin
      if (vld[k] && (asid[k] == look_asid_i || pte[k][PTE_G]) &&
          (mega[k] ? tag[k][19:10] == look_vpn_i[19:10]
                   : tag[k] == look_vpn_i))
      begin
        hit_o = 1'b1;
        hit_pte_o = pte[k];
        hit_mega_o = mega[k];
      end
    end
  end

  // round-robin replacement keeps the cache tiny
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      vld <= '0;
      wptr <= '0;
    end
    else if (flush_i)
    begin
      vld <= '0;
    end
    else if (fill_i)
    begin
      vld[wptr] <= 1'b1;
      wptr <= wptr + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (fill_i)
    begin
      tag[wptr] <= fill_vpn_i;
      asid[wptr] <= fill_asid_i;
      pte[wptr] <= fill_pte_i;
      mega[wptr] <= fill_mega_i;
    end
  end
endmodule : tlpw_cache
`default_nettype wire

// [hdl/tlpw_walker.sv]
// Purpose: hardware walker for the 32-bit two-level page scheme
// Assumes: memory port holds pte reads and atomic compare-updates
// Notes: pmp/pma verdicts arrive with each memory response
`default_nettype none
// How it works
// - the translation answer waits until the entry update is acknowledged.
// - all harts share one accessed/dirty scheme, chosen by a control bit.
// - the walker only ever sets accessed and dirty, never clears them.
// - an upper-level leaf maps a 4 MiB page, aligned or page fault.
// - reservation sets stay within one 4 KiB page; pages are 4 KiB.
// - translate only in supervisor or user; start at root times page size.
// - fetch entry at base plus index times four; bad read gives access fault.
// - invalid, write-without-read or reserved bits raise a page fault.
// - read or execute marks a leaf; else descend, below zero faults.
// - upper-level leaf with nonzero low page number is misaligned.
// - user bit checked against privilege, user-access and access type.
// - shadow stack violations raise an access fault.
// - read/write/execute bits must permit the access type.
// - fault mode: clear accessed, or clear dirty on store, page faults.
// - update mode: check store, compare and set bits, retry on mismatch.
// - physical address from entry page number, offset and low vpn.
// - every table access is one full 32-bit word.
// - cache hits need matching asid or a global entry.
// - accessed/dirty updates go to memory, never through the cache.
// - speculative walks set no dirty bit, fault silently, obey fences.
// - all 22 page number bits are used to form addresses.
// - vpn is two 10-bit indices over a 12-bit offset.
// - supervisor may touch user pages only with user-access, never execute.
module tlpw_walker
  import tlpw_pkg::*;
#(
  parameter int ASID_W = 9
)
(
  input wire logic clk_sys_i, // core clock
  input wire logic rst_n_i, // async reset, active low
  // apb slave
  input wire logic psel, // select
  input wire logic penable, // access phase
  input wire logic pwrite, // write
  input wire logic [7:0] paddr, // byte address
  input wire logic [31:0] pwdata, // write data
  output logic [31:0] prdata, // read data
  output logic pready, // ready
  output logic pslverr, // error on unmapped address
  // translation request
  input wire logic req_valid_i, // request valid
  output logic req_ready_o, // request accepted
  input wire logic [31:0] req_va_i, // virtual address
  input wire logic [1:0] req_type_i, // load, store or fetch
  input wire logic [1:0] req_priv_i, // effective privilege
  input wire logic req_spec_i, // speculative walk
  input wire logic req_sstack_i, // shadow stack access
  output logic rsp_valid_o, // one-cycle answer
  output logic [33:0] rsp_pa_o, // physical address
  output logic [1:0] rsp_fault_o, // fault code
  // memory port
  output logic mem_req_o, // request valid
  input wire logic mem_gnt_i, // request accepted
  output logic mem_amo_o, // atomic compare-update
  output logic [33:0] mem_addr_o, // byte address of entry
  output logic [31:0] mem_cmp_o, // expected old entry
  output logic [31:0] mem_wdata_o, // new entry
  input wire logic mem_rvalid_i, // response valid
  input wire logic [31:0] mem_rdata_i, // read data
  input wire logic mem_match_i, // compare matched, stored
  input wire logic mem_err_i // pma/pmp violation
);
  typedef enum {IDLE, LOOK, FETCH, WAIT, AMO, AWAIT, DONE} tlpw_st_type;
  tlpw_st_type st;
  logic [21:0] root;
  logic [ASID_W-1:0] asid;
  logic [31:0] ctrl;
  logic fence_pend;
  logic [31:0] va;
  logic [1:0] typ, priv;
  logic spec, sstk, lvl, killed;
  logic [33:0] base;
  logic [31:0] pte;
  logic [1:0] flt;
  logic [33:0] pa;
  logic [31:0] walks, faults;
  logic hit, hit_mega, do_fill;
  logic [31:0] hit_pte;
  logic apb_acc;
  logic [1:0] chk;
  logic need_ad;

  assign apb_acc = psel && penable;
  assign pready = 1'b1;
  assign pslverr = apb_acc && (paddr > REG_FENCE || paddr[1:0] != 2'h0);

  // ==========================================================
  // apb registers: root, control, fence strobe
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      root <= '0;
      asid <= '0;
      ctrl <= CTRL_RESET;
    end
    else if (apb_acc && pwrite && paddr == REG_ROOT)
    begin
      root <= pwdata[21:0];
      asid <= pwdata[22+ASID_W-1:22];
    end
    else if (apb_acc && pwrite && paddr == REG_CTRL)
    begin
      ctrl <= {28'h0000000, pwdata[3:0]};
    end
  end

  always_comb
  begin
    case (paddr)
      REG_ROOT: prdata = {{(10-ASID_W){1'b0}}, asid, root};
      REG_CTRL: prdata = ctrl;
      REG_STATUS: prdata = {walks[15:0], faults[15:0]};
      default: prdata = 32'h00000000;
    endcase
  end

  // fence write flushes the cache; walks in flight are marked stale
  assign fence_pend = apb_acc && pwrite && paddr == REG_FENCE;

  // ==========================================================
  // translation cache
  assign do_fill = st == DONE && flt == FLT_NONE && !killed;
  tlpw_cache #(.DEPTH(CACHE_DEPTH), .ASID_W(ASID_W)) u_cache (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .flush_i(fence_pend),
    .look_vpn_i(va[31:12]),
    .look_asid_i(asid),
    .hit_o(hit),
    .hit_pte_o(hit_pte),
    .hit_mega_o(hit_mega),
    .fill_i(do_fill),
    .fill_vpn_i(va[31:12]),
    .fill_asid_i(asid),
    .fill_pte_i(pte),
    .fill_mega_i(lvl)
  );

  // ==========================================================
  // leaf checks, ordered as the walk orders them
  always_comb
  begin
    chk = FLT_NONE;
    need_ad = !pte[PTE_A] || (typ == ACC_STORE && !pte[PTE_D]);
    if (lvl && pte[19:10] != 10'h000)
      chk = FLT_PAGE;
    else if (priv == PRIV_U && !pte[PTE_U])
      chk = FLT_PAGE;
    else if (priv == PRIV_S && pte[PTE_U] &&
             (typ == ACC_FETCH || !ctrl[CTRL_SUA]))
      chk = FLT_PAGE;
    else if (sstk && !(pte[PTE_W] && !pte[PTE_R] == 1'b0 &&
             typ != ACC_FETCH && !pte[PTE_X] && pte[PTE_W]))
      chk = FLT_ACCESS;
    else if ((typ == ACC_FETCH && !pte[PTE_X]) ||
             (typ == ACC_STORE && !pte[PTE_W]) ||
             (typ == ACC_LOAD && !pte[PTE_R] &&
              !(ctrl[CTRL_MXR] && pte[PTE_X])))
      chk = FLT_PAGE;
    else if (need_ad && !ctrl[CTRL_HWAD])
      chk = FLT_PAGE;
  end

  // ==========================================================
  // walk state machine
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st <= IDLE;
      va <= '0;
      typ <= ACC_LOAD;
      priv <= PRIV_U;
      spec <= 1'b0;
      sstk <= 1'b0;
      lvl <= 1'b1;
      base <= '0;
      pte <= '0;
      flt <= FLT_NONE;
      killed <= 1'b0;
    end
    else
    begin
      if (fence_pend)
        killed <= 1'b1;
      case (st)
        IDLE:
        begin
          if (req_valid_i)
          begin
            va <= req_va_i;
            typ <= req_type_i;
            priv <= req_priv_i;
            spec <= req_spec_i;
            sstk <= req_sstack_i;
            lvl <= 1'b1; // LEVELS-1
            base <= {12'h000, root} * BASE_PAGE_BYTES;
            flt <= FLT_NONE;
            killed <= fence_pend; // a fence on the take edge still counts
            if (!ctrl[CTRL_ACT] || req_priv_i > PRIV_S)
            begin
              flt <= FLT_ACCESS; // no translation outside s/u
              st <= DONE;
            end
            else
              st <= LOOK;
          end
        end
        LOOK:
        begin
          // a cached leaf that still needs a/d is refetched from memory
          if (hit && hit_pte[PTE_A] &&
              (typ != ACC_STORE || hit_pte[PTE_D]))
          begin
            pte <= hit_pte;
            lvl <= hit_mega;
            st <= AMO;
          end
          else
            st <= FETCH;
        end
        FETCH:
        begin
          if (mem_gnt_i)
            st <= WAIT;
        end
        WAIT:
        begin
          if (mem_rvalid_i)
            pte <= mem_rdata_i;
          if (mem_rvalid_i && mem_err_i)
          begin
            flt <= FLT_ACCESS;
            st <= DONE;
          end
          else if (mem_rvalid_i)
            st <= AMO; // evaluate entry next cycle
        end
        AMO:
        begin
          if (!pte[PTE_V] || (pte[PTE_W] && !pte[PTE_R]) ||
              (!(pte[PTE_R] || pte[PTE_X]) &&
               (pte[PTE_D] || pte[PTE_A] || pte[PTE_U])))
          begin
            flt <= FLT_PAGE;
            st <= DONE;
          end
          else if (!(pte[PTE_R] || pte[PTE_X]))
          begin
            if (!lvl)
            begin
              flt <= FLT_PAGE;
              st <= DONE;
            end
            else
            begin
              lvl <= 1'b0;
              base <= {pte[31:10], 12'h000}; // full ppn
              st <= FETCH;
            end
          end
          else if (chk != FLT_NONE)
          begin
            flt <= chk;
            st <= DONE;
          end
          else if (need_ad && !(spec && typ == ACC_STORE))
            st <= AWAIT;
          else if (need_ad)
          begin
            flt <= FLT_PAGE; // speculative store never dirties
            st <= DONE;
          end
          else
            st <= DONE;
        end
        AWAIT:
        begin
          if (mem_rvalid_i && mem_err_i)
          begin
            flt <= FLT_ACCESS;
            st <= DONE;
          end
          else if (mem_rvalid_i && mem_match_i)
          begin
            pte <= mem_wdata_o;
            st <= DONE;
          end
          else if (mem_rvalid_i)
            st <= FETCH;
        end
        DONE:
          st <= IDLE;
        default:
          st <= IDLE;
      endcase
    end
  end

  // memory port: fetch uses one word at base plus index times four
  logic amo_sent;
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      amo_sent <= 1'b0;
    else if (st != AWAIT)
      amo_sent <= 1'b0;
    else if (mem_gnt_i)
      amo_sent <= 1'b1;
  end

  assign mem_req_o = st == FETCH || (st == AWAIT && !amo_sent);
  assign mem_amo_o = st == AWAIT;
  assign mem_addr_o = base + ({24'h000000, lvl ? va[31:22] : va[21:12]} *
                      ENTRY_BYTES);
  assign mem_cmp_o = pte;
  // only ever sets bits
  assign mem_wdata_o = pte | (32'h1 << PTE_A) |
                       ((typ == ACC_STORE) ? (32'h1 << PTE_D) : 32'h0);

  // ==========================================================
  // answer: address formed from entry and va
  always_comb
  begin
    pa = {pte[31:10], va[11:0]};
    if (lvl)
      pa[21:12] = va[21:12];
  end

  assign req_ready_o = st == IDLE;
  // speculative walks report no fault
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rsp_valid_o <= 1'b0;
      rsp_pa_o <= '0;
      rsp_fault_o <= FLT_NONE;
    end
    else
    begin
      rsp_valid_o <= st == DONE;
      rsp_pa_o <= pa; // 4 KiB pages bound reservations
      rsp_fault_o <= spec ? FLT_NONE : flt;
    end
  end

  // counters shown in the status register
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      walks <= '0;
      faults <= '0;
    end
    else if (st == DONE)
    begin
      walks <= walks + 32'h1;
      if (flt != FLT_NONE)
        faults <= faults + 32'h1;
    end
  end

  // ==========================================================
  // checks
  chk_amo_sets: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    mem_req_o && mem_amo_o |-> (mem_wdata_o & mem_cmp_o) == mem_cmp_o)
    else $error("update clears a bit");
  chk_req_held: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    mem_req_o && !mem_gnt_i |=> mem_req_o && $stable(mem_addr_o))
    else $error("memory request dropped");
  chk_spec_nofault: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) rsp_valid_o && spec |-> rsp_fault_o == FLT_NONE)
    else $error("speculative fault");
  chk_pa_offset: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    rsp_valid_o |-> rsp_pa_o[11:0] == va[11:0])
    else $error("offset changed");
  chk_addr_word: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    mem_req_o |-> mem_addr_o[1:0] == 2'h0)
    else $error("unaligned entry access");
  chk_upd_before: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    st == AWAIT && !mem_rvalid_i |=> !rsp_valid_o)
    else $error("answer before update");
  chk_fence_fill: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    fence_pend && st != IDLE |=> !do_fill)
    else $error("stale fill");
  chk_answer_one: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    rsp_valid_o |=> !rsp_valid_o)
    else $error("answer not one cycle");
  cov_hit: cover property (@(posedge clk_sys_i) st == LOOK && hit);
  cov_amo: cover property (@(posedge clk_sys_i) st == AWAIT && mem_rvalid_i);
  cov_fault: cover property (@(posedge clk_sys_i)
    rsp_valid_o && rsp_fault_o == FLT_PAGE);
endmodule : tlpw_walker
`default_nettype wire

// [tb/tlpw_mem_model.sv]
// Purpose: memory side of the walker, serving entry reads and updates
// Assumes: one request in flight; one response per granted request
// Notes: slow_i stretches answers; err_addr_i marks one bad address
`default_nettype none
module tlpw_mem_model
  import tlpw_pkg::*;
(
  input wire logic clk_sys_i, // core clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic mem_req_i, // request valid
  output logic mem_gnt_o, // request accepted
  input wire logic mem_amo_i, // compare-update
  input wire logic [33:0] mem_addr_i, // entry byte address
  input wire logic [31:0] mem_cmp_i, // expected old entry
  input wire logic [31:0] mem_wdata_i, // new entry
  output logic mem_rvalid_o, // response valid
  output logic [31:0] mem_rdata_o, // read data
  output logic mem_match_o, // compare matched
  output logic mem_err_o, // protection violation
  input wire logic slow_i, // stall each answer
  input wire logic [33:0] err_addr_i // address that faults
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] words [logic [33:0]];
  logic busy;
  logic amo_q;
  logic [33:0] addr_q;
  logic [31:0] cmp_q;
  logic [31:0] wd_q;
  logic [2:0] wait_q;
  logic [31:0] cur;
  // ==========================================================
  // grant a held request, answer it once with a whole word
  always @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mem_gnt_o <= 1'b0;
      mem_rvalid_o <= 1'b0;
      mem_match_o <= 1'b0;
      mem_err_o <= 1'b0;
      mem_rdata_o <= 32'h0;
      busy <= 1'b0;
    end
    else
    begin
      mem_gnt_o <= 1'b0;
      mem_rvalid_o <= 1'b0;
      mem_match_o <= 1'b0;
      mem_err_o <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o; // idle data never looks valid
      if (mem_req_i && mem_gnt_o)
      begin
        busy <= 1'b1;
        amo_q <= mem_amo_i;
        addr_q <= mem_addr_i;
        cmp_q <= mem_cmp_i;
        wd_q <= mem_wdata_i;
        wait_q <= slow_i ? 3'h4 : 3'h0;
      end
      else if (mem_req_i && !busy)
        mem_gnt_o <= 1'b1;
      if (busy && wait_q != 3'h0)
        wait_q <= wait_q - 3'h1;
      else if (busy)
      begin
        cur = words.exists(addr_q) ? words[addr_q] : 32'h0;
        busy <= 1'b0;
        mem_rvalid_o <= 1'b1;
        mem_rdata_o <= cur;
        mem_err_o <= (addr_q == err_addr_i);
        // update happens in the word itself, atomically
        if (amo_q && addr_q != err_addr_i && cur == cmp_q)
        begin
          words[addr_q] = wd_q;
          mem_match_o <= 1'b1;
        end
      end
    end
  end
endmodule : tlpw_mem_model
`default_nettype wire

// [tb/tb_two_level_page_walker.sv]
// Purpose: self-checking bench for the page walker
// Assumes: apb answers at once; translations one at a time
// Notes: tables are written straight into the memory model
`default_nettype none
module tb_two_level_page_walker import tlpw_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [21:0] ROOT = 22'h000010;
  localparam logic [21:0] NXT = 22'h000020;
  localparam logic [21:0] LP = 22'h30a5c5; // top bit set on purpose
  localparam logic [21:0] LP2 = 22'h2000c3;
  localparam logic [21:0] MP = 22'h300c00;
  localparam logic [31:0] VA = 32'h12345678;
  localparam logic [33:0] L1A = {ROOT, 12'h0} + {22'h0, VA[31:22], 2'h0};
  localparam logic [33:0] L0A = {NXT, 12'h0} + {22'h0, VA[21:12], 2'h0};
  localparam logic [33:0] PA4K = {LP, VA[11:0]};
  localparam logic [33:0] PAMB = {MP[21:10], VA[21:0]};
  localparam logic [31:0] PTR = {NXT, 10'h001};
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, req_ready_o, rsp_valid_o;
  logic req_valid_i = 1'b0, req_spec_i = 1'b0, req_sstack_i = 1'b0;
  logic [31:0] req_va_i = 32'h0;
  logic [1:0] req_type_i = 2'h0, req_priv_i = 2'h0, rsp_fault_o;
  logic [33:0] rsp_pa_o, mem_addr_o;
  logic mem_req_o, mem_gnt_i, mem_amo_o, mem_rvalid_i;
  logic mem_match_i, mem_err_i, slow = 1'b0, spec = 1'b0, ss = 1'b0;
  logic [31:0] mem_cmp_o, mem_wdata_o, mem_rdata_i;
  logic [33:0] err_addr = 34'h3ffffffff;
  int errors = 0;
  int checks_done = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  tlpw_walker i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
    .req_va_i(req_va_i), .req_type_i(req_type_i), .req_priv_i(req_priv_i),
    .req_spec_i(req_spec_i), .req_sstack_i(req_sstack_i),
    .rsp_valid_o(rsp_valid_o), .rsp_pa_o(rsp_pa_o),
    .rsp_fault_o(rsp_fault_o), .mem_req_o(mem_req_o),
    .mem_gnt_i(mem_gnt_i), .mem_amo_o(mem_amo_o), .mem_addr_o(mem_addr_o),
    .mem_cmp_o(mem_cmp_o), .mem_wdata_o(mem_wdata_o),
    .mem_rvalid_i(mem_rvalid_i), .mem_rdata_i(mem_rdata_i),
    .mem_match_i(mem_match_i), .mem_err_i(mem_err_i));
  tlpw_mem_model i_mem (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .mem_req_i(mem_req_o), .mem_gnt_o(mem_gnt_i), .mem_amo_i(mem_amo_o),
    .mem_addr_i(mem_addr_o), .mem_cmp_i(mem_cmp_o),
    .mem_wdata_i(mem_wdata_o), .mem_rvalid_o(mem_rvalid_i),
    .mem_rdata_o(mem_rdata_i), .mem_match_o(mem_match_i),
    .mem_err_o(mem_err_i), .slow_i(slow), .err_addr_i(err_addr));
  // ==========================================================
  // helpers
  function automatic logic [31:0] pte(input logic [21:0] p,
    input logic [7:0] f);
    return {p, 2'h0, f};
  endfunction : pte
  task automatic chk(input string nm, input logic [33:0] exp, got);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  // one apb transfer; released only after the sampling edge
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    @(posedge clk_sys_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    chk("pready", 34'h1, {33'h0, pready});
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  // one translation, then fault and address compared
  task automatic go(input logic [1:0] typ, pv, flt, input logic [33:0] pa);
    int n;
    @(posedge clk_sys_i);
    req_valid_i <= 1'b1;
    req_va_i <= VA;
    req_type_i <= typ;
    req_priv_i <= pv;
    req_spec_i <= spec;
    req_sstack_i <= ss;
    n = 0;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (req_ready_o !== 1'b1 && n < 100);
    req_valid_i <= 1'b0;
    n = 0;
    do begin @(negedge clk_sys_i); n++; end
    while (rsp_valid_o !== 1'b1 && n < 200);
    chk("rsp_valid", 34'h1, {33'h0, rsp_valid_o});
    chk("fault", {32'h0, flt}, {32'h0, rsp_fault_o});
    if (flt == FLT_NONE && !spec)
      chk("pa", pa, rsp_pa_o);
  endtask : go
  // fresh tables, a fence, then one translation
  task automatic tw(input logic [31:0] l1, l0, input logic [1:0] typ, pv,
    flt, input logic [33:0] pa);
    i_mem.words[L1A] = l1;
    i_mem.words[L0A] = l0;
    wr(REG_FENCE, 32'h0);
    go(typ, pv, flt, pa);
  endtask : tw
  // ==========================================================
  // main sequence
  initial
  begin
    logic [31:0] q;
    logic e;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    apb(1'b0, REG_CTRL, 32'h0, q, e);
    chk("ctrl reset", {2'h0, CTRL_RESET}, {2'h0, q});
    apb(1'b0, 8'h10, 32'h0, q, e);
    chk("unmapped err", 34'h1, {33'h0, e});
    wr(REG_ROOT, {1'b0, 9'h001, ROOT});
    wr(REG_CTRL, 32'h0000000c);
    tw(PTR, pte(LP, 8'h43), ACC_LOAD, PRIV_S, FLT_NONE, PA4K);
    chk("leaf kept", {2'h0, pte(LP, 8'h43)}, {2'h0, i_mem.words[L0A]});
    tw(pte(MP, 8'hc7), 0, ACC_STORE, PRIV_S, FLT_NONE, PAMB);
    tw(pte(MP | 22'h1, 8'hc7), 0, ACC_STORE, PRIV_S, FLT_PAGE, 0);
    tw(32'h0, 0, ACC_LOAD, PRIV_S, FLT_PAGE, 0);
    tw(PTR, pte(LP, 8'h45), ACC_LOAD, PRIV_S, FLT_PAGE, 0);
    tw(PTR, PTR, ACC_LOAD, PRIV_S, FLT_PAGE, 0);
    tw(PTR, pte(LP, 8'h43), ACC_STORE, PRIV_S, FLT_PAGE, 0);
    tw(PTR, pte(LP, 8'h43), ACC_FETCH, PRIV_S, FLT_PAGE, 0);
    tw(PTR, pte(LP, 8'h49), ACC_LOAD, PRIV_S, FLT_PAGE, 0);
    tw(PTR, pte(LP, 8'h43), ACC_LOAD, PRIV_U, FLT_PAGE, 0);
    tw(PTR, pte(LP, 8'h53), ACC_LOAD, PRIV_S, FLT_PAGE, 0);
    $display("test decode done");
    wr(REG_CTRL, 32'h0000000f);
    tw(PTR, pte(LP, 8'h53), ACC_LOAD, PRIV_S, FLT_NONE, PA4K);
    tw(PTR, pte(LP, 8'h59), ACC_FETCH, PRIV_S, FLT_PAGE, 0);
    tw(PTR, pte(LP, 8'h49), ACC_LOAD, PRIV_S, FLT_NONE, PA4K);
    err_addr <= L1A;
    tw(PTR, pte(LP, 8'h43), ACC_LOAD, PRIV_S, FLT_ACCESS, 0);
    err_addr <= 34'h3ffffffff;
    tw(PTR, pte(LP, 8'h43), ACC_LOAD, 2'h2, FLT_ACCESS, 0);
    ss = 1'b1;
    tw(PTR, pte(LP, 8'h43), ACC_LOAD, PRIV_S, FLT_ACCESS, 0);
    ss = 1'b0;
    $display("test permission done");
    slow <= 1'b1;
    tw(PTR, pte(LP, 8'h07), ACC_STORE, PRIV_S, FLT_NONE, PA4K);
    chk("ad set", {2'h0, pte(LP, 8'hc7)}, {2'h0, i_mem.words[L0A]});
    spec = 1'b1;
    tw(PTR, pte(LP, 8'h47), ACC_STORE, PRIV_S, FLT_NONE, 0);
    chk("no dirty", {2'h0, pte(LP, 8'h47)}, {2'h0, i_mem.words[L0A]});
    tw(32'h0, 0, ACC_LOAD, PRIV_S, FLT_NONE, 0);
    spec = 1'b0;
    slow <= 1'b0;
    wr(REG_CTRL, 32'h0000000b); // every hart in fault mode
    tw(PTR, pte(LP, 8'h03), ACC_LOAD, PRIV_S, FLT_PAGE, 0);
    tw(PTR, pte(LP, 8'h47), ACC_STORE, PRIV_S, FLT_PAGE, 0);
    wr(REG_CTRL, 32'h0000000f);
    $display("test accessed dirty done");
    tw(PTR, pte(LP, 8'h43), ACC_LOAD, PRIV_S, FLT_NONE, PA4K);
    i_mem.words[L0A] = pte(LP2, 8'h43);
    go(ACC_LOAD, PRIV_S, FLT_NONE, PA4K); // cached entry
    wr(REG_ROOT, {1'b0, 9'h002, ROOT});
    go(ACC_LOAD, PRIV_S, FLT_NONE, {LP2, VA[11:0]});
    i_mem.words[L0A] = pte(LP, 8'h43);
    wr(REG_FENCE, 32'h0);
    go(ACC_LOAD, PRIV_S, FLT_NONE, PA4K);
    apb(1'b0, REG_STATUS, 32'h0, q, e);
    chk("walk count", 34'h1a, {18'h0, q[31:16]});
    $display("test cache done");
    complete_run();
  end
  // ==========================================================
  // watchdog: the whole run needs a few hundred cycles
  initial
  begin
    #100us;
    errors++;
    complete_run();
  end
endmodule : tb_two_level_page_walker
`default_nettype wire
